// ---- src/stpel_regs.svh ----
// Register offsets, field positions, reset values and counts
`ifndef STPEL_REGS_SVH
`define STPEL_REGS_SVH
`define STPEL_ADDR_CTRL   12'h000
`define STPEL_ADDR_DATA   12'h004
`define STPEL_ADDR_STAT   12'h008
`define STPEL_CTRL_W      12
`define STPEL_CTRL_RST    12'h000
`define STPEL_ST_OVR      0
`define STPEL_ST_PARITY_UNDERRUN_FLAG     1
`define STPEL_ST_FRAMING_FLAG     2
`define STPEL_ST_TX_HOLDING_EMPTY    3
`define STPEL_ST_RBFULL   4
`define STPEL_ST_BUSY     5
`define STPEL_ST_TB7      6
`define STPEL_ST_RB9      7
`define STPEL_SOFT_RESET_CMD_BIT   0
`define STPEL_TICK_LAST   4'hF
`define STPEL_IO_LEN      4'h8
`define STPEL_RD_NONE     32'h0000_0000
`endif

// ---- src/stpel_pkg.sv ----
// Types shared by the serial transmit and error flag logic
package stpel_pkg;
    typedef enum logic [1:0] {
        STPEL_IO,
        STPEL_UART7,
        STPEL_UART8,
        STPEL_UART9
    } stpel_mode_e;

    typedef struct packed {
        logic        tx_ninth_bit;
        logic        duty_mode;
        logic        bit_order_sel;
        logic        stop_length_sel;
        logic        double_buffer_enable;
        logic        shift_edge_sel;
        logic        shift_clock_dir_sel;
        logic        send_gate_enable;
        logic        even_sel;
        logic        parity_enable;
        stpel_mode_e mode;
    } stpel_ctrl_s;

    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic [2:0] stop_votes;
    } stpel_rx_s;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_WAIT,
        TX_SHIFT
    } stpel_tx_state_e;
endpackage

// ---- src/stpel_sync.sv ----
// Two-flop synchroniser with edge detection for one outside input
`timescale 1ns/1ns
`default_nettype none
module stpel_sync (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            last_r <= 1'b0;
        end else begin
            last_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~last_r;
    assign fall  = ~sync_r & last_r;
endmodule
`default_nettype wire

// ---- src/stpel_core.sv ----
// Serial transmit engine, parity and error flags behind an APB slave
//
// Summary of operation
// - UART: 4-bit counter, tick every 16 base pulses
// - Internal shift clock: shift on its falling edge
// - External shift clock: shift on selected edge
// - UART frame starts at next tick fall
// - Gate enabled: start only while clear-to-send low
// - Clear-to-send high: finish frame, then hold
// - Held off: empty interrupt if double buffer, new frame waits
// - Duty mode ORs line with tick waveform
// - Double buffer: move, interrupt, set holding-empty
// - External clock: missed next frame sets underrun
// - Internal clock stops after frame, no underrun
// - Single buffer: interrupt on frame completion
// - Parity generated in 7/8-bit UART, even/odd
// - Sent parity kept in bit seven/ninth
// - Receive transfer: check parity, flag mismatch
// - Overrun set on unread frame unless internal clock, read clears
// - Framing reads zero in shift-link modes
// - Underrun only with double buffer, read clears
// - Framing: stop majority zero sets flag
// - Shift-link bit order selects MSB or LSB first; UART is always LSB first
// - One or two stop bits sent
`timescale 1ns/1ns
`default_nettype none
`include "stpel_regs.svh"
module stpel_core (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic [11:0]       paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              serial_base_clock,
    input  wire logic              shift_clock_pin_i,
    output logic                   shift_clock_pin_o,
    output logic                   shift_clock_pin_oe,
    input  wire logic              clear_to_send_in,
    output logic                   serial_out_pin,
    output logic                   tx_irq,
    input  wire logic              rx_xfer_evt,
    input  wire stpel_pkg::stpel_rx_s rx_frame
);
    import stpel_pkg::*;

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == `STPEL_ADDR_CTRL) || (a == `STPEL_ADDR_DATA) ||
                  (a == `STPEL_ADDR_STAT);
    endfunction

    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = d[7 - i];
        end
    endfunction

    // Outside inputs: base clock, shift clock pin, clear-to-send
    logic [2:0] async_in;
    logic [2:0] lvl;
    logic [2:0] rise;
    logic [2:0] fall;
    assign async_in = {clear_to_send_in, shift_clock_pin_i, serial_base_clock};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            stpel_sync u_sync (
                .sys_clk  (sys_clk),
                .rst_n    (rst_n),
                .async_in (async_in[g]),
                .level    (lvl[g]),
                .rise     (rise[g]),
                .fall     (fall[g])
            );
        end
    endgenerate

    stpel_ctrl_s     ctrl_r;
    stpel_tx_state_e state_r;
    logic [31:0]     prdata_r;
    logic            pready_r;
    logic            pslverr_r;
    logic [3:0]      tick_cnt_r;
    logic [7:0]      hold_r;
    logic            hold_full_r;
    logic [12:0]     frame_r;
    logic [3:0]      len_r;
    logic            par_r;
    logic            sclk_r;
    logic            sclk_oe_r;
    logic            und_arm_r;
    logic            tx_bit_seven_r;
    logic            tx_irq_r;
    logic            serial_out_r;
    logic [7:0]      rx_data_r;
    logic            rx_ninth_r;
    logic            rx_full_r;
    logic            ovr_r;
    logic            parity_underrun_flag_r;
    logic            framing_flag_r;

    logic is_uart;
    logic io_int;
    logic io_ext;
    logic base_pulse;
    logic tick;
    logic ext_edge;
    logic cts_ok;
    logic shift_evt;
    logic count_evt;
    logic frame_done;
    logic move;
    logic underrun_set;
    logic par_err_set;
    logic access;
    logic rd_stat;
    logic rd_data;
    logic wr_ctrl;
    logic wr_data;
    logic sw_rst;
    logic tx_line;
    logic [7:0] st;

    assign is_uart    = ctrl_r.mode != STPEL_IO;
    assign io_int     = !is_uart && !ctrl_r.shift_clock_dir_sel;
    assign io_ext     = !is_uart && ctrl_r.shift_clock_dir_sel;
    assign base_pulse = rise[0];
    assign tick       = is_uart && base_pulse &&
                        (tick_cnt_r == `STPEL_TICK_LAST);
    assign ext_edge   = ctrl_r.shift_edge_sel ? rise[1] : fall[1];
    assign cts_ok     = !ctrl_r.send_gate_enable || !lvl[2];

    // APB: one wait state, completion when pready is seen high
    assign access  = psel && penable && pready_r;
    assign rd_stat = access && !pwrite && paddr == `STPEL_ADDR_STAT;
    assign rd_data = access && !pwrite && paddr == `STPEL_ADDR_DATA;
    assign wr_ctrl = access && pwrite && paddr == `STPEL_ADDR_CTRL;
    assign wr_data = access && pwrite && paddr == `STPEL_ADDR_DATA;
    assign sw_rst  = access && pwrite && paddr == `STPEL_ADDR_STAT &&
                     pwdata[`STPEL_SOFT_RESET_CMD_BIT];

    always_comb begin
        st = 8'h00;
        st[`STPEL_ST_OVR]    = ovr_r;
        st[`STPEL_ST_PARITY_UNDERRUN_FLAG]   = parity_underrun_flag_r &&
                               !(io_ext && !ctrl_r.double_buffer_enable);
        st[`STPEL_ST_FRAMING_FLAG]   = framing_flag_r && is_uart;
        st[`STPEL_ST_TX_HOLDING_EMPTY]  = !hold_full_r;
        st[`STPEL_ST_RBFULL] = rx_full_r;
        st[`STPEL_ST_BUSY]   = state_r != TX_IDLE;
        st[`STPEL_ST_TB7]    = tx_bit_seven_r;
        st[`STPEL_ST_RB9]    = rx_ninth_r;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= `STPEL_RD_NONE;
        end else begin
            pready_r  <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !addr_ok(paddr);
            if (psel && penable && !pready_r && !pwrite) begin
                case (paddr)
                    `STPEL_ADDR_CTRL: prdata_r <= {20'h0, ctrl_r};
                    `STPEL_ADDR_DATA: prdata_r <= {24'h0, rx_data_r};
                    `STPEL_ADDR_STAT: prdata_r <= {24'h0, st};
                    default:          prdata_r <= `STPEL_RD_NONE;
                endcase
            end
        end
    end

    // Control; hardware records sent parity in the ninth bit
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_r <= stpel_ctrl_s'(`STPEL_CTRL_RST);
        end else if (wr_ctrl) begin
            ctrl_r <= stpel_ctrl_s'(pwdata[`STPEL_CTRL_W-1:0]);
        end else if (frame_done && ctrl_r.mode == STPEL_UART8 &&
                     ctrl_r.parity_enable) begin
            ctrl_r.tx_ninth_bit <= par_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !is_uart) begin
            tick_cnt_r <= 4'h0;
        end else if (base_pulse) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
        end
    end

    // Frame image, LSB leaves first; spare upper ones act as stop bits
    logic [12:0] frame_nxt;
    logic [3:0]  len_nxt;
    logic        par_nxt;
    logic [3:0]  stop_cnt;
    logic        par7;
    logic        par8;
    always_comb begin
        stop_cnt = ctrl_r.stop_length_sel ? 4'h2 : 4'h1;
        par7 = ctrl_r.even_sel ? ^hold_r[6:0] : ~^hold_r[6:0];
        par8 = ctrl_r.even_sel ? ^hold_r : ~^hold_r;
        par_nxt = 1'b0;
        case (ctrl_r.mode)
            STPEL_UART7: begin
                par_nxt   = par7;
                frame_nxt = ctrl_r.parity_enable ?
                            {4'hF, par7, hold_r[6:0], 1'b0} :
                            {5'h1F, hold_r[6:0], 1'b0};
                len_nxt   = 4'h8 + {3'h0, ctrl_r.parity_enable} + stop_cnt;
            end
            STPEL_UART8: begin
                par_nxt   = par8;
                frame_nxt = ctrl_r.parity_enable ?
                            {3'h7, par8, hold_r, 1'b0} :
                            {4'hF, hold_r, 1'b0};
                len_nxt   = 4'h9 + {3'h0, ctrl_r.parity_enable} + stop_cnt;
            end
            STPEL_UART9: begin
                frame_nxt = {3'h7, ctrl_r.tx_ninth_bit, hold_r, 1'b0};
                len_nxt   = 4'hA + stop_cnt;
            end
            default: begin
                // Order is frozen here, so a late change cannot split a frame
                // Pad repeats the bit on the line, so a refill holds it
                frame_nxt = {4'hF, ctrl_r.bit_order_sel ? rev8(hold_r) :
                             hold_r, frame_r[0]};
                len_nxt   = `STPEL_IO_LEN;
            end
        endcase
    end

    always_comb begin
        if (is_uart) begin
            shift_evt = tick;
            count_evt = tick;
        end else if (io_int) begin
            shift_evt = base_pulse && sclk_r;
            count_evt = base_pulse && !sclk_r;
        end else begin
            shift_evt = ext_edge;
            count_evt = ext_edge;
        end
    end

    assign frame_done = state_r == TX_SHIFT && count_evt && len_r == 4'h1;
    assign move       = state_r == TX_IDLE && hold_full_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || sw_rst) begin
            state_r <= TX_IDLE;
            frame_r <= 13'h1FFF;
            len_r   <= 4'h0;
            par_r   <= 1'b0;
        end else begin
            case (state_r)
                TX_IDLE: begin
                    if (move) begin
                        frame_r <= frame_nxt;
                        len_r   <= len_nxt;
                        par_r   <= par_nxt;
                        state_r <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    // Gate checked only at start, so a running frame ends
                    if (!is_uart || (tick && cts_ok)) begin
                        state_r <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (shift_evt) begin
                        frame_r <= {1'b1, frame_r[12:1]};
                    end
                    if (count_evt) begin
                        len_r <= len_r - 4'h1;
                    end
                    if (frame_done) begin
                        state_r <= TX_IDLE;
                    end
                end
                default: state_r <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || sw_rst) begin
            hold_r      <= 8'h00;
            hold_full_r <= 1'b0;
        end else if (wr_data) begin
            hold_r      <= pwdata[7:0];
            hold_full_r <= 1'b1;
        end else if (move) begin
            hold_full_r <= 1'b0;
        end
    end

    // Clock idles high and only toggles inside a frame
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sclk_r    <= 1'b1;
            sclk_oe_r <= 1'b0;
        end else begin
            sclk_oe_r <= io_int;
            if (state_r == TX_SHIFT && io_int && base_pulse) begin
                sclk_r <= !sclk_r;
            end else if (state_r != TX_SHIFT) begin
                sclk_r <= 1'b1;
            end
        end
    end

    assign underrun_set = state_r == TX_IDLE && und_arm_r && io_ext &&
                          ctrl_r.double_buffer_enable && !hold_full_r &&
                          ext_edge;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || sw_rst) begin
            und_arm_r <= 1'b0;
        end else if (frame_done) begin
            und_arm_r <= 1'b1;
        end else if (move) begin
            und_arm_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_irq_r       <= 1'b0;
            tx_bit_seven_r <= 1'b0;
        end else begin
            tx_irq_r <= (move && ctrl_r.double_buffer_enable) ||
                        (frame_done && !ctrl_r.double_buffer_enable);
            if (frame_done && ctrl_r.mode == STPEL_UART7 &&
                ctrl_r.parity_enable) begin
                tx_bit_seven_r <= par_r;
            end
        end
    end

    assign tx_line = is_uart ? (state_r != TX_SHIFT || frame_r[0]) :
                     frame_r[0];

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            serial_out_r <= 1'b1;
        end else begin
            serial_out_r <= tx_line ||
                            (is_uart && ctrl_r.duty_mode &&
                             tick_cnt_r[3]);
        end
    end

    // Receive-side checks on transfer into the second receive buffer
    assign par_err_set = rx_xfer_evt && ctrl_r.parity_enable &&
        ((ctrl_r.mode == STPEL_UART7 &&
          (ctrl_r.even_sel ? ^rx_frame.data[6:0] : ~^rx_frame.data[6:0])
          != rx_frame.data[7]) ||
         (ctrl_r.mode == STPEL_UART8 &&
          (ctrl_r.even_sel ? ^rx_frame.data : ~^rx_frame.data)
          != rx_frame.ninth));

    always_ff @(posedge sys_clk) begin
        if (!rst_n || sw_rst) begin
            rx_data_r  <= 8'h00;
            rx_ninth_r <= 1'b0;
            rx_full_r  <= 1'b0;
        end else if (rx_xfer_evt && !(rx_full_r && !io_int)) begin
            // Overrun keeps the unread frame
            rx_data_r  <= rx_frame.data;
            rx_ninth_r <= rx_frame.ninth;
            rx_full_r  <= 1'b1;
        end else if (rd_data) begin
            rx_full_r  <= 1'b0;
        end
    end

    // Sets win over read clears in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n || sw_rst) begin
            ovr_r <= 1'b0;
        end else if (rx_xfer_evt && rx_full_r && !io_int) begin
            ovr_r <= 1'b1;
        end else if (rd_stat || rd_data) begin
            ovr_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || sw_rst) begin
            parity_underrun_flag_r <= 1'b0;
        end else if (par_err_set || underrun_set) begin
            parity_underrun_flag_r <= 1'b1;
        end else if (rd_stat) begin
            parity_underrun_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || sw_rst) begin
            framing_flag_r <= 1'b0;
        end else if (rx_xfer_evt && is_uart &&
                     !maj3(rx_frame.stop_votes)) begin
            framing_flag_r <= 1'b1;
        end else if (rd_stat) begin
            framing_flag_r <= 1'b0;
        end
    end

    assign prdata             = prdata_r;
    assign pready             = pready_r;
    assign pslverr            = pslverr_r;
    assign shift_clock_pin_o  = sclk_r;
    assign shift_clock_pin_oe = sclk_oe_r;
    assign serial_out_pin     = serial_out_r;
    assign tx_irq             = tx_irq_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_tick_wrap;
        tick |=> tick_cnt_r == 4'h0 ##15 (tick_cnt_r != 4'h0 || !is_uart);
    endproperty
    a_tick_wrap: assert property (p_tick_wrap)
        else $error("tick counter did not wrap");

    property p_uart_start;
        state_r == TX_WAIT && tick && cts_ok && !ctrl_r.duty_mode && !sw_rst
        |=> state_r == TX_SHIFT ##1 !serial_out_pin;
    endproperty
    a_uart_start: assert property (p_uart_start)
        else $error("start bit not sent at tick");

    property p_cts_hold;
        state_r == TX_WAIT && is_uart && ctrl_r.send_gate_enable && lvl[2]
        |=> state_r != TX_SHIFT;
    endproperty
    a_cts_hold: assert property (p_cts_hold)
        else $error("frame started while gated");

    property p_move_irq;
        move && ctrl_r.double_buffer_enable && !wr_data && !sw_rst
        |=> tx_irq && st[`STPEL_ST_TX_HOLDING_EMPTY];
    endproperty
    a_move_irq: assert property (p_move_irq)
        else $error("move without interrupt or empty flag");

    property p_underrun;
        underrun_set && !sw_rst |=> parity_underrun_flag_r;
    endproperty
    a_underrun: assert property (p_underrun)
        else $error("underrun not flagged");

    property p_single_irq;
        frame_done && !ctrl_r.double_buffer_enable |=> tx_irq;
    endproperty
    a_single_irq: assert property (p_single_irq)
        else $error("no interrupt on completion");

    property p_overrun;
        rx_xfer_evt && rx_full_r && !io_int && !sw_rst |=> ovr_r;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged");

    property p_framing;
        rx_xfer_evt && is_uart && !maj3(rx_frame.stop_votes) && !sw_rst
        |=> framing_flag_r;
    endproperty
    a_framing: assert property (p_framing)
        else $error("framing error not flagged");

    property p_sclk_idle;
        state_r != TX_SHIFT && $past(state_r) != TX_SHIFT |-> sclk_r;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("shift clock toggling outside frame");
endmodule
`default_nettype wire

// ---- tb/stpel_far_model.sv ----
// Far-side device: UART receiver with flow control, shift-link sampler
`timescale 1ns/1ns
`default_nettype none
module stpel_far_model #(
    parameter int BIT_NS = 12800
) (
    input  wire logic  line,
    input  wire logic  sclk,
    input  wire logic  sclk_oe,
    input  wire logic  flow_en,
    input  wire logic  release_hold,
    output logic       clear_to_send,
    output logic [7:0] uart_byte,
    output logic       uart_stop,
    output int         uart_cnt,
    output logic [7:0] io_byte,
    output int         io_cnt
);
    logic [7:0] sh_r;
    logic [7:0] io_r;
    logic       hold_r = 1'b0;
    int         io_n = 0;
    initial begin
        uart_cnt = 0;
        io_cnt = 0;
    end
    // High means stop sending; only raised when flow control is in use
    assign clear_to_send = flow_en & hold_r;
    // Mid-bit sampling by time; tolerant only of the bench's own base clock
    always begin
        @(negedge line);
        #(BIT_NS / 2);
        if (line === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                #(BIT_NS);
                sh_r = {line, sh_r[7:1]};
            end
            #(BIT_NS);
            uart_stop = line;
            uart_byte = sh_r;
            uart_cnt++;
            if (flow_en)
                hold_r = 1'b1;
        end
    end
    always @(posedge release_hold) hold_r = 1'b0;
    always @(posedge sclk) begin
        if (sclk_oe === 1'b1) begin
            io_r = {line, io_r[7:1]};
            io_n++;
            if (io_n == 8) begin
                io_byte = io_r;
                io_cnt++;
                io_n = 0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Testbench for the serial transmit and error flag block
`timescale 1ns/1ns
`default_nettype none
`include "stpel_regs.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: %h %h", $time, a, b); end end
module tb_top;
    import stpel_pkg::*;
    logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, serial_base_clock = 0, clear_to_send_in;
    logic shift_clock_pin_o, shift_clock_pin_oe, serial_out_pin, tx_irq;
    logic rx_xfer_evt = 0, flow_en = 0, rel = 0, ext_sclk = 1;
    stpel_rx_s rx_frame = '0;
    logic [7:0] ub, iob, xb;
    logic us;
    int uc, ic, n_errors = 0, num_checks = 0, cyc = 0, irq_n = 0;
    always #50 sys_clk = ~sys_clk;
    always #400 serial_base_clock = ~serial_base_clock;
    stpel_core dut_u (.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .serial_base_clock,
        .shift_clock_pin_i(ext_sclk), .shift_clock_pin_o, .shift_clock_pin_oe,
        .clear_to_send_in, .serial_out_pin, .tx_irq, .rx_xfer_evt,
        .rx_frame);
    stpel_far_model far_u (.line(serial_out_pin), .sclk(shift_clock_pin_o),
        .sclk_oe(shift_clock_pin_oe), .flow_en, .release_hold(rel),
        .clear_to_send(clear_to_send_in), .uart_byte(ub), .uart_stop(us),
        .uart_cnt(uc), .io_byte(iob), .io_cnt(ic));
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (tx_irq === 1'b1)
            irq_n++;
        if (cyc == 40000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic evt(input logic [7:0] d, input logic n,
                       input logic [2:0] v);
        @(posedge sys_clk);
        rx_xfer_evt <= 1;
        rx_frame <= '{d, n, v};
        @(posedge sys_clk);
        rx_xfer_evt <= 0;
    endtask
    task automatic send(input logic [31:0] c, input logic [7:0] d, int n0);
        apb(1, `STPEL_ADDR_CTRL, c);
        apb(1, `STPEL_ADDR_DATA, {24'h0, d});
        while (uc == n0) @(posedge sys_clk);
        repeat (400) @(posedge sys_clk);
    endtask
    // External shift clock, 800 ns, falling edge shifts; sample late in it
    task automatic clk_in(input int n);
        repeat (n) begin
            ext_sclk <= 0;
            repeat (4) @(posedge sys_clk);
            ext_sclk <= 1;
            repeat (4) @(posedge sys_clk);
            xb = {serial_out_pin, xb[7:1]};
        end
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1;
        apb(0, `STPEL_ADDR_CTRL, 0);
        `CHK(rd, 32'h0000_0000)
        apb(0, 12'h00C, 0);
        `CHK({err, rd}, {1'b1, `STPEL_RD_NONE})
        $display("test regs done");
        send(32'h0000_0002, 8'hA5, uc);
        `CHK({ub, us}, {8'hA5, 1'b1})
        `CHK(irq_n, 1)
        send(32'h0000_000D, 8'h34, uc);
        `CHK(ub, 8'hB4)
        apb(0, `STPEL_ADDR_STAT, 0);
        `CHK(rd[6], 1'b1)
        send(32'h0000_0005, 8'h34, uc);
        `CHK(ub, 8'h34)
        $display("test uart done");
        flow_en <= 1;
        send(32'h0000_0012, 8'h5A, uc);
        apb(1, `STPEL_ADDR_DATA, 32'h0000_003C);
        repeat (3000) @(posedge sys_clk);
        `CHK({uc, serial_out_pin}, {32'd4, 1'b1})
        rel <= 1;
        while (uc == 4) @(posedge sys_clk);
        repeat (400) @(posedge sys_clk);
        `CHK(ub, 8'h3C)
        flow_en <= 0;
        send(32'h0000_0103, 8'h69, uc);
        `CHK({ub, us}, {8'h69, 1'b0})
        $display("test gate done");
        apb(1, `STPEL_ADDR_CTRL, 0);
        apb(1, `STPEL_ADDR_DATA, 32'h0000_00C1);
        while (ic == 0) @(posedge sys_clk);
        `CHK(iob, 8'hC1)
        `CHK(shift_clock_pin_oe, 1'b1)
        apb(1, `STPEL_ADDR_CTRL, 32'h0000_0200);
        apb(1, `STPEL_ADDR_DATA, 32'h0000_00C1);
        while (ic == 1) @(posedge sys_clk);
        `CHK(iob, 8'h83)
        $display("test shift done");
        apb(1, `STPEL_ADDR_CTRL, 32'h0000_00A0);
        apb(1, `STPEL_ADDR_DATA, 32'h0000_0096);
        apb(0, `STPEL_ADDR_STAT, 0);
        `CHK({irq_n, rd[5:3]}, {32'd9, 3'b101})
        `CHK(shift_clock_pin_oe, 1'b0)
        apb(1, `STPEL_ADDR_DATA, 32'h0000_005A);
        apb(0, `STPEL_ADDR_STAT, 0);
        `CHK(rd[3], 1'b0)
        clk_in(8);
        `CHK(xb, 8'h96)
        clk_in(8);
        `CHK({irq_n, xb}, {32'd10, 8'h5A})
        clk_in(1);
        apb(0, `STPEL_ADDR_STAT, 0);
        `CHK(rd[1], 1'b1)
        apb(0, `STPEL_ADDR_STAT, 0);
        `CHK(rd[1], 1'b0)
        $display("test ext done");
        apb(1, `STPEL_ADDR_CTRL, 32'h0000_0006);
        evt(8'h01, 1'b1, 3'b100);
        apb(0, `STPEL_ADDR_STAT, 0);
        `CHK(rd[2:0], 3'b110)
        apb(0, `STPEL_ADDR_STAT, 0);
        `CHK(rd[2:0], 3'b000)
        apb(0, `STPEL_ADDR_DATA, 0);
        evt(8'h01, 1'b0, 3'b011);
        evt(8'h02, 1'b0, 3'b011);
        apb(0, `STPEL_ADDR_STAT, 0);
        `CHK(rd[2:0], 3'b001)
        apb(0, `STPEL_ADDR_DATA, 0);
        `CHK(rd[7:0], 8'h01)
        apb(0, `STPEL_ADDR_STAT, 0);
        `CHK(rd[2:0], 3'b000)
        $display("test flags done");
        end_sim();
    end
endmodule
`default_nettype wire
